// ==== src/line_driver_config_register.sv ====
// Operation
// - Configuration register is selected by register-address bits 3 and 2.
// - Power-on reset clears every configuration bit to zero.
// - Bit 7 picks filter corner: 0 is 500kHz, 1 is 1MHz.
// - One filter bit steers both line and auxiliary input filters.
// - Bits 6 and 0 are unused and carry no function.
// - Open-drain bit 5: 1 sinks low side, 0 sources high side.
// - Bit 4 high gives push-pull drive; low gives open-drain.
// - Driver enabled when bit 3 or external enable pin is high.
// - Level bit drives line only while enabled and transmit is high.
// - Source floats on 0, sink floats on 1, push-pull follows level.
// - Bit 1 disables the receiver and forces receive output high.
// - Line-level status follows line input even with receiver disabled.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none
module line_driver_config_register (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ldc_pkg::ldc_axi_req_t axiReq,
  output ldc_pkg::ldc_axi_rsp_t axiRsp,
  input wire logic hostInterfaceSelectPin,
  input wire logic pushPullModePin,
  input wire logic sourceModePin,
  input wire logic driverEnablePin,
  input wire logic txIn,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe,
  output logic rxOut,
  output logic receiveFilterSelect,
  output logic auxFilterSelect
);
  import ldc_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [CFG_W-1:0] cfgReg;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
  } ldc_state_t;

  ldc_state_t st;
  ldc_state_t next_st;
  ldc_cfg_t cfg;
  ldc_line_t line;
  logic serialMode;

  function automatic logic isCfg(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2] == CFG_INDEX;
  endfunction

  function automatic logic isStat(input logic [ADDR_W-1:0] a);
    return a == LINE_STAT_ADDR;
  endfunction

  // ---------------------------------------------------------------------------
  // Effective configuration
  // ---------------------------------------------------------------------------
  always_comb begin
    serialMode = hostInterfaceSelectPin;
    if (serialMode) begin
      cfg.filterFast = st.cfgReg[BIT_FILTER];
      cfg.sinkMode = st.cfgReg[BIT_SINK];
      cfg.pushPull = st.cfgReg[BIT_PUSH_PULL];
      cfg.softEnable = st.cfgReg[BIT_SOFT_EN];
      cfg.level = st.cfgReg[BIT_LEVEL];
      cfg.rxDisable = st.cfgReg[BIT_RX_DIS];
    end else begin
      // Pin mode: mode pins set drive type, other used bits behave as zero.
      cfg.filterFast = 1'b0;
      cfg.sinkMode = ~sourceModePin;
      cfg.pushPull = pushPullModePin;
      cfg.softEnable = 1'b0;
      cfg.level = 1'b0;
      cfg.rxDisable = 1'b0;
    end
  end

  ldc_line_logic u_line (
    .cfg(cfg),
    .driverEnablePin(driverEnablePin),
    .txIn(txIn),
    .lineIn(lineIn),
    .line(line)
  );

  assign lineOut = line.lineOut;
  assign lineOe = line.lineOe;
  assign rxOut = line.rxOut;
  assign receiveFilterSelect = line.filterFast;
  assign auxFilterSelect = line.auxFilterFast;

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  always_comb begin
    axiRsp.awready = ~st.awHeld & ~st.bValid;
    axiRsp.wready = ~st.wHeld & ~st.bValid;
    axiRsp.bvalid = st.bValid;
    axiRsp.bresp = st.bResp;
    axiRsp.arready = ~st.rValid;
    axiRsp.rvalid = st.rValid;
    axiRsp.rdata = st.rData;
    axiRsp.rresp = st.rResp;
  end

  always_comb begin
    logic [CFG_W-1:0] wv;
    wv = '0;
    next_st = st;
    if (axiReq.awvalid && axiRsp.awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = axiReq.wdata;
      next_st.wStrb = axiReq.wstrb;
    end
    if (st.awHeld && st.wHeld) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = RESP_SLVERR;
      if (isCfg(st.awAddr)) begin
        next_st.bResp = RESP_OKAY;
        // Unused bits stay zero; writes to them are dropped.
        wv = st.wData[CFG_W-1:0] & CFG_WMASK;
        if (st.wStrb[0] && serialMode) begin
          next_st.cfgReg = wv;
        end
      end else if (isStat(st.awAddr)) begin
        next_st.bResp = RESP_OKAY;
      end
    end
    if (st.bValid && axiReq.bready) begin
      next_st.bValid = 1'b0;
    end
    if (axiReq.arvalid && axiRsp.arready) begin
      next_st.rValid = 1'b1;
      next_st.rData = '0;
      next_st.rResp = RESP_OKAY;
      if (isCfg(axiReq.araddr)) begin
        next_st.rData = {24'h000000, st.cfgReg};
      end else if (isStat(axiReq.araddr)) begin
        // Bit 0 is the inverted line level, bit 1 the driver state.
        next_st.rData = {30'h00000000, line.driverOn, ~lineIn};
      end else begin
        next_st.rResp = RESP_SLVERR;
      end
    end else if (st.rValid && axiReq.rready) begin
      next_st.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.cfgReg <= CFG_RESET;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ==== src/ldc_pkg.sv ====
`default_nettype none
package ldc_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CFG_W = 8;
  // Two register-address bits select the configuration register at index 1.
  localparam logic [1:0] CFG_INDEX = 2'h1;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] LINE_STAT_ADDR = 4'h8;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [CFG_W-1:0] CFG_WMASK = 8'hBE;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_FILTER = 7;
  localparam int BIT_SINK = 5;
  localparam int BIT_PUSH_PULL = 4;
  localparam int BIT_SOFT_EN = 3;
  localparam int BIT_LEVEL = 2;
  localparam int BIT_RX_DIS = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } ldc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } ldc_axi_rsp_t;

  typedef struct packed {
    logic filterFast;
    logic sinkMode;
    logic pushPull;
    logic softEnable;
    logic level;
    logic rxDisable;
  } ldc_cfg_t;

  typedef struct packed {
    logic lineOut;
    logic lineOe;
    logic rxOut;
    logic filterFast;
    logic auxFilterFast;
    logic driverOn;
  } ldc_line_t;
endpackage
`default_nettype wire

// ==== src/ldc_line_logic.sv ====
`default_nettype none
module ldc_line_logic (
  input wire ldc_pkg::ldc_cfg_t cfg,
  input wire logic driverEnablePin,
  input wire logic txIn,
  input wire logic lineIn,
  output ldc_pkg::ldc_line_t line
);
  import ldc_pkg::*;
  logic enabled;
  logic driveVal;

  always_comb begin
    enabled = cfg.softEnable | driverEnablePin;
    // Line follows transmit unless transmit is high, then the level bit takes over.
    driveVal = txIn ? cfg.level : 1'b0;
    line.lineOut = driveVal;
    line.lineOe = 1'b0;
    if (enabled) begin
      if (cfg.pushPull) begin
        line.lineOe = 1'b1;
      end else if (cfg.sinkMode) begin
        line.lineOe = ~driveVal;
      end else begin
        line.lineOe = driveVal;
      end
    end
    line.rxOut = cfg.rxDisable ? 1'b1 : ~lineIn;
    line.filterFast = cfg.filterFast;
    line.auxFilterFast = cfg.filterFast;
    line.driverOn = enabled;
  end
endmodule
`default_nettype wire

// ==== bench/ldc_properties.sv ====
`default_nettype none
module ldc_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ldc_pkg::ldc_axi_req_t axiReq,
  input wire ldc_pkg::ldc_axi_rsp_t axiRsp,
  input wire logic hostInterfaceSelectPin,
  input wire logic pushPullModePin,
  input wire logic sourceModePin,
  input wire logic driverEnablePin,
  input wire logic txIn,
  input wire logic lineIn,
  input wire logic lineOut,
  input wire logic lineOe,
  input wire logic rxOut,
  input wire logic receiveFilterSelect,
  input wire logic auxFilterSelect
);
  timeunit 1ns;
  timeprecision 100ps;
  import ldc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_filter_pair: assert property (receiveFilterSelect == auxFilterSelect)
    else $error("filter selects differ");
  a_pin_filter: assert property (!hostInterfaceSelectPin |-> !receiveFilterSelect)
    else $error("pin mode filter set");
  a_pin_rx: assert property (!hostInterfaceSelectPin |-> rxOut == !lineIn)
    else $error("pin mode rx wrong");
  a_pin_float: assert property (!hostInterfaceSelectPin && !driverEnablePin |-> !lineOe)
    else $error("disabled driver drives");
  a_pin_drive: assert property (!hostInterfaceSelectPin && driverEnablePin
    && (pushPullModePin || !sourceModePin) |-> lineOe && !lineOut) else $error("no drive low");
  a_rd_latency: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  a_wr_latency: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |-> ##2 axiRsp.bvalid) else $error("write answer late");
  a_reset_clear: assert property ($rose(resetn) && !driverEnablePin
    |-> !receiveFilterSelect && !lineOe) else $error("config not cleared");
  a_stat_level: assert property (axiReq.arvalid && axiRsp.arready
    && axiReq.araddr == LINE_STAT_ADDR |=> axiRsp.rdata[0] == $past(!lineIn))
    else $error("status level wrong");
  c_write: cover property (axiRsp.bvalid && axiReq.bready);
  c_read: cover property (axiRsp.rvalid && axiReq.rready);
  c_error: cover property (axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR);
endmodule
bind line_driver_config_register ldc_properties u_props (.*);
`default_nettype wire

// ==== bench/ldc_line_model.sv ====
`default_nettype none
module ldc_line_model (
  input wire logic clk_sys,
  input wire logic lineOut,
  input wire logic lineOe,
  output var logic lineIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic flip = 1'b0;
  // The line has no pull, so an undriven line wanders every cycle.
  always @(posedge clk_sys) flip <= !flip;
  always_comb lineIn = lineOe ? lineOut : flip;
endmodule
`default_nettype wire

// ==== bench/test_line_driver_config_register.sv ====
`default_nettype none
module test_line_driver_config_register;
  timeunit 1ns;
  timeprecision 100ps;
  import ldc_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0;
  ldc_axi_req_t req = '0;
  ldc_axi_rsp_t rsp, s;
  logic sel = 1'b1, ppPin = 1'b0, srcPin = 1'b0, enPin = 1'b0, txIn = 1'b0;
  logic lineIn, lineOut, lineOe, rxOut, filt, aux, pp, sk, v, oe, f;
  logic [7:0] r;
  logic [31:0] p;
  logic [33:0] rq[$], bq[$];
  int err_count = 0, checks_done = 0, seed = 9600;
  always #25 clk_sys = !clk_sys;
  line_driver_config_register dut (.clk_sys(clk_sys), .resetn(resetn), .axiReq(req),
    .axiRsp(rsp), .hostInterfaceSelectPin(sel), .pushPullModePin(ppPin),
    .sourceModePin(srcPin), .driverEnablePin(enPin), .txIn(txIn), .lineIn(lineIn),
    .lineOut(lineOut), .lineOe(lineOe), .rxOut(rxOut), .receiveFilterSelect(filt),
    .auxFilterSelect(aux));
  ldc_line_model u_line (.clk_sys(clk_sys), .lineOut(lineOut), .lineOe(lineOe),
    .lineIn(lineIn));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [33:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic xfer(input bit rd, input logic [3:0] a, input logic [31:0] d,
    input logic [33:0] e);
    int i;
    if (rd) rq.push_back(e);
    else bq.push_back(e);
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= !rd;
    req.wvalid <= !rd;
    req.bready <= !rd;
    req.arvalid <= rd;
    req.rready <= rd;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      if (!(req.awvalid | req.wvalid | req.bready | req.arvalid | req.rready)) break;
      s = rsp;
      @(posedge clk_sys);
      if (s.awready) req.awvalid <= 1'b0;
      if (s.wready) req.wvalid <= 1'b0;
      if (s.bvalid) req.bready <= 1'b0;
      if (s.arready) req.arvalid <= 1'b0;
      if (s.rvalid) req.rready <= 1'b0;
    end
    if (i == 20) begin
      err_count++;
      report_and_stop();
    end
    @(posedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (rsp.rvalid && req.rready) check("read", {rsp.rresp, rsp.rdata}, rq.pop_front());
    if (rsp.bvalid && req.bready) check("write", {rsp.bresp, 32'h0}, bq.pop_front());
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    xfer(1, CFG_ADDR, 32'h0, {RESP_OKAY, 32'h0});
    xfer(0, CFG_ADDR, 32'hFF, {RESP_OKAY, 32'h0});
    xfer(1, CFG_ADDR, 32'h0, {RESP_OKAY, 32'hBE});
    xfer(0, 4'h0, 32'hFF, {RESP_SLVERR, 32'h0});
    xfer(1, 4'hC, 32'h0, {RESP_SLVERR, 32'h0});
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      p = $random(seed);
      if (i[0]) r[2] = 1'b0;
      sel <= p[0];
      ppPin <= p[1];
      srcPin <= p[2];
      enPin <= p[3];
      txIn <= p[4];
      xfer(0, CFG_ADDR, {24'h0, r}, {RESP_OKAY, 32'h0});
      if (p[0]) xfer(1, CFG_ADDR, 32'h0, {RESP_OKAY, 24'h0, r & 8'hBE});
      @(negedge clk_sys);
      pp = p[0] ? r[4] : p[1];
      sk = p[0] ? r[5] : !p[2];
      v = p[4] & p[0] & r[2];
      oe = ((p[0] & r[3]) | p[3]) & (pp | (sk ? !v : v));
      f = p[0] & r[7];
      check("line", {rxOut, filt, aux, lineOe, lineOe & lineOut},
        {(p[0] & r[1]) | !lineIn, f, f, oe, oe & (pp ? v : !sk)});
      @(posedge clk_sys);
      if (oe) xfer(1, LINE_STAT_ADDR, 32'h0, {RESP_OKAY, 30'h0, 1'b1, !(pp ? v : !sk)});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
